//--- flag_cond_defs.svh
`ifndef FLAG_COND_DEFS_SVH
`define FLAG_COND_DEFS_SVH

// Register byte offsets on the bus
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_RET 8'h08
// Core registers sit at 8'h40 + 4 * index, index 0 to 9
`define CORE_PAGE 2'h1
`define CORE_COUNT 4'hA

// Core register indices
`define IDX_STEP_FIRST 4'h4
`define IDX_STEP_SECOND 4'h5
`define IDX_MOD_START 4'h6
`define IDX_MOD_END 4'h7
`define IDX_CNT0 4'h8
`define IDX_CNT1 4'h9

// Control register fields
`define CTRL_LOW_CLEAR_BIT 0
`define CTRL_SAT_BIT 1

// Status register fields
`define ST_NEG_BIT 0
`define ST_ZERO_BIT 1
`define ST_OVF36_BIT 2
`define ST_OVF32_BIT 3
`define ST_RAND_BIT 4
`define ST_BUSY_BIT 5

// Reset values
`define CTRL_RST 2'h0
`define CORE_RST 16'h0000
`define RET_RST 16'h0000
`define RAND_SEED 4'h0

// Ten-state random sequence: five of ten states give a set bit
`define RAND_PATTERN 10'h2CA
`define RAND_LAST 4'h9

// Accumulator limits on saturation
`define SAT_POS 36'h0_7FFF_FFFF
`define SAT_NEG 36'hF_8000_0000

`endif

//--- flag_cond_pkg.sv
package flag_cond_pkg;

   // Post-modification modes of a compound access
   typedef enum logic [1:0] {
      zero_then_plus_mode = 2'h0,
      plus_then_zero_mode = 2'h1,
      plus_two_mode = 2'h2,
      step_mode = 2'h3
   } xmode_t;

   // Exchanged register codes; codes 0 to 9 live inside this block
   typedef enum logic [4:0] {
      xr_ptr0 = 5'h00, xr_ptr1 = 5'h01, xr_ptr2 = 5'h02, xr_ptr3 = 5'h03,
      xr_step_first = 5'h04, xr_step_second = 5'h05,
      xr_mod_start = 5'h06, xr_mod_end = 5'h07,
      xr_cnt0 = 5'h08, xr_cnt1 = 5'h09, xr_cnt2 = 5'h0A,
      xr_x = 5'h0B, xr_y = 5'h0C, xr_y_low = 5'h0D,
      xr_rom_ptr = 5'h0E, xr_ret_addr = 5'h0F, xr_rom_step = 5'h10,
      xr_status_word = 5'h11, xr_arith_ctl = 5'h12,
      xr_serial_ctl = 5'h13, xr_serial_rate = 5'h14, xr_serial_data = 5'h15,
      xr_tdm_ctl = 5'h16, xr_par_ctl = 5'h17,
      xr_acc0 = 5'h18, xr_acc0_low = 5'h19, xr_acc1 = 5'h1A, xr_acc1_low = 5'h1B
   } xreg_t;

   // Condition test codes
   typedef enum logic [4:0] {
      cond_nonneg = 5'h00, cond_neg = 5'h01, cond_eq = 5'h02, cond_ne = 5'h03,
      cond_gt = 5'h04, cond_le = 5'h05,
      cond_ovf36_set = 5'h06, cond_ovf36_clear = 5'h07,
      cond_ovf32_set = 5'h08, cond_ovf32_clear = 5'h09,
      cond_count0_nonneg = 5'h0A, cond_count0_neg = 5'h0B,
      cond_count1_nonneg = 5'h0C, cond_count1_neg = 5'h0D,
      cond_rand_set = 5'h0E, cond_rand_clear = 5'h0F,
      cond_always = 5'h10, cond_never = 5'h11
   } cond_t;

   // Source of a data unit result
   typedef enum logic [1:0] {
      src_function = 2'h0,
      src_special = 2'h1,
      src_transfer = 2'h2,
      src_move = 2'h3
   } flag_src_t;

   // Sequencer states, Gray coded
   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_read = 2'b01,
      seq_load = 2'b11,
      seq_store = 2'b10
   } seq_t;

   typedef struct packed {
      xmode_t mode;
      logic [1:0] ptr_sel;
      xreg_t target;
   } compound_cmd_t;

   typedef struct packed {
      flag_src_t src;
      logic ovf36;
      logic [35:0] value;
   } dau_result_t;

endpackage

//--- compound_access_and_condition_flags.sv
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "flag_cond_defs.svh"
// Summary of operation
// - one pointer reads, then writes back old
// - latch, load, store; mode-specific post-modification
// - pointer chosen from four RAM pointers
// - exchanged register chosen from full register set
// - high-half load clears low half when enabled
// - accumulator load saturates when enabled
// - modulo compare both cycles; wrap on the +1 cycle
// - only function and special results touch flags
// - negative flag is result bit 35
// - zero flag when bits 35..0 zero
// - 36-bit overflow flag from true sign
// - 32-bit overflow when bits 35..31 differ
// - sign and zero tests from flags
// - greater and less-equal tests combine flags
// - overflow tests report flags, set and clear
// - counter tests report sign, then increment
// - ten-state random bit, advanced per random-bit test
// - interrupt return write resets random sequence
// - interrupt return changes only inside service
// - always passes, never fails
// - plain modulo wrap at end with +1
module compound_access_and_condition_flags (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cmd_valid,
   input wire flag_cond_pkg::compound_cmd_t cmd,
   output logic busy,
   output logic [15:0] ram_addr,
   output logic ram_rd,
   output logic ram_wr,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata,
   input wire logic [35:0] xreg_old,
   output flag_cond_pkg::xreg_t xreg_sel,
   output logic xreg_wr,
   output logic [35:0] xreg_wdata,
   input wire logic dau_valid,
   input wire flag_cond_pkg::dau_result_t dau,
   input wire logic cond_valid,
   input wire flag_cond_pkg::cond_t cond,
   output logic cond_done,
   output logic cond_pass,
   input wire logic ret_wr,
   input wire logic [15:0] ret_wdata,
   input wire logic in_isr,
   output logic [15:0] interrupt_return_reg,
   output logic flag_negative,
   output logic flag_zero,
   output logic flag_ovf36,
   output logic flag_ovf32
);

   // Bits 35..31 not all equal: value does not fit in 32 bits
   function automatic logic ovf32_of(input logic [35:0] v);
      ovf32_of = !((&v[35:31]) | ~(|v[35:31]));
   endfunction

   // Registers loaded through their upper half
   function automatic logic is_high(input flag_cond_pkg::xreg_t r);
      is_high = (r == flag_cond_pkg::xr_y) | (r == flag_cond_pkg::xr_acc0) |
                (r == flag_cond_pkg::xr_acc1);
   endfunction

   // Next pointer value, wrapping to the modulo start at the end
   function automatic logic [15:0] post_mod(input logic [15:0] p,
         input logic [15:0] step, input logic wrap, input logic [15:0] start,
         input logic [15:0] last);
      post_mod = (wrap && p == last) ? start : 16'(p + step);
   endfunction

   logic [15:0] core [0:9];
   logic [1:0] ctrl;
   flag_cond_pkg::seq_t st;
   flag_cond_pkg::compound_cmd_t cur;
   logic [35:0] temp;
   logic [3:0] rand_state;
   logic bus_wr_q;
   logic [7:0] bus_addr_q;

   // Bus address phase decode
   wire logic bus_take = hsel & hready & htrans[1] & ce;
   wire logic [7:0] ra = haddr[7:0];
   wire logic ra_core = ra[7:6] == `CORE_PAGE && ra[5:2] < `CORE_COUNT && ra[1:0] == 2'h0;
   wire logic wa_core = bus_addr_q[7:6] == `CORE_PAGE && bus_addr_q[5:2] < `CORE_COUNT &&
                        bus_addr_q[1:0] == 2'h0;
   wire logic [3:0] wa_idx = bus_addr_q[5:2];
   wire logic bus_ctrl_wr = bus_wr_q && bus_addr_q == `OFF_CTRL;
   wire logic bus_ret_wr = bus_wr_q && bus_addr_q == `OFF_RET;
   wire logic bus_core_wr = bus_wr_q && wa_core;

   // Low-clear and saturate controls
   wire logic low_clear_ctl = ctrl[`CTRL_LOW_CLEAR_BIT];
   wire logic saturate_ctl = ctrl[`CTRL_SAT_BIT];

   // Random bit and status word
   wire logic [9:0] rand_pattern = `RAND_PATTERN;
   wire logic rand_bit = rand_pattern[rand_state];
   wire logic [31:0] status_word = {26'h0, busy, rand_bit, flag_ovf32, flag_ovf36,
                                    flag_zero, flag_negative};

   // Read data selection
   wire logic [31:0] rd_word =
      ra_core ? {16'h0, core[ra[5:2]]} :
      ra == `OFF_CTRL ? {30'h0, ctrl} :
      ra == `OFF_STATUS ? status_word :
      ra == `OFF_RET ? {16'h0, interrupt_return_reg} : 32'h0;

   // Bus slave: zero wait states, read data captured at the address phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_wr_q <= 1'b0;
         bus_addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         bus_wr_q <= bus_take & hwrite;
         bus_addr_q <= ra;
         if (bus_take && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   // Control register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CTRL_RST;
      end else if (ce && bus_ctrl_wr) begin
         ctrl <= hwdata[1:0];
      end
   end

   // Compound access: pointer, target and post-modification decode
   wire logic cmd_take = cmd_valid && st == flag_cond_pkg::seq_idle;
   wire logic [3:0] ptr_idx = {2'h0, cur.ptr_sel};
   wire logic [15:0] cur_ptr = core[ptr_idx];
   wire logic tgt_int = cur.target <= flag_cond_pkg::xr_cnt1;
   wire logic [3:0] tgt_idx = cur.target[3:0];
   wire logic cmd_int = cmd.target <= flag_cond_pkg::xr_cnt1;
   wire logic [35:0] cmd_old = cmd_int ? {20'h0, core[cmd.target[3:0]]} : xreg_old;
   wire logic [15:0] mod_start = core[`IDX_MOD_START];
   wire logic [15:0] mod_end = core[`IDX_MOD_END];

   // Read cycle step: +1 for plus-then-zero, first step for step mode
   wire logic [15:0] rd_step =
      cur.mode == flag_cond_pkg::plus_then_zero_mode ? 16'h0001 :
      cur.mode == flag_cond_pkg::step_mode ? core[`IDX_STEP_FIRST] : 16'h0000;
   wire logic rd_wrap = cur.mode == flag_cond_pkg::plus_then_zero_mode;
   wire logic [15:0] rd_next = post_mod(cur_ptr, rd_step, rd_wrap, mod_start, mod_end);

   // Write cycle step: +1, +2 or second step
   wire logic [15:0] wr_step =
      cur.mode == flag_cond_pkg::zero_then_plus_mode ? 16'h0001 :
      cur.mode == flag_cond_pkg::plus_two_mode ? 16'h0002 :
      cur.mode == flag_cond_pkg::step_mode ? core[`IDX_STEP_SECOND] : 16'h0000;
   wire logic wr_wrap = cur.mode == flag_cond_pkg::zero_then_plus_mode;
   wire logic [15:0] wr_next = post_mod(cur_ptr, wr_step, wr_wrap, mod_start, mod_end);

   // Shape the loaded word for the target register
   wire logic tgt_high = is_high(cur.target);
   wire logic tgt_low = cur.target == flag_cond_pkg::xr_y_low ||
                        cur.target == flag_cond_pkg::xr_acc0_low ||
                        cur.target == flag_cond_pkg::xr_acc1_low;
   wire logic tgt_acc = cur.target >= flag_cond_pkg::xr_acc0;
   wire logic [15:0] keep_low = low_clear_ctl ? 16'h0000 : temp[15:0];
   wire logic [35:0] load_raw =
      tgt_high ? {{4{ram_rdata[15]}}, ram_rdata, keep_low} :
      tgt_low ? {temp[35:16], ram_rdata} : {20'h0, ram_rdata};
   wire logic sat_hit = tgt_acc && saturate_ctl && ovf32_of(load_raw);
   wire logic [35:0] load_val = !sat_hit ? load_raw :
      load_raw[35] ? `SAT_NEG : `SAT_POS;

   // Word that goes back to RAM
   wire logic [15:0] temp_word = is_high(cur.target) ? temp[31:16] : temp[15:0];

   // Sequencer: accept, read, load, store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= flag_cond_pkg::seq_idle;
         cur <= '0;
         temp <= 36'h0_0000_0000;
         busy <= 1'b0;
      end else if (ce) begin
         case (st)
            flag_cond_pkg::seq_idle: begin
               if (cmd_take) begin
                  cur <= cmd;
                  temp <= cmd_old;
                  busy <= 1'b1;
                  st <= flag_cond_pkg::seq_read;
               end
            end
            flag_cond_pkg::seq_read: st <= flag_cond_pkg::seq_load;
            flag_cond_pkg::seq_load: st <= flag_cond_pkg::seq_store;
            flag_cond_pkg::seq_store: begin
               busy <= 1'b0;
               st <= flag_cond_pkg::seq_idle;
            end
            default: st <= flag_cond_pkg::seq_idle;
         endcase
      end
   end

   // RAM and exchanged-register strobes, one pointer for both accesses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ram_addr <= 16'h0000;
         ram_rd <= 1'b0;
         ram_wr <= 1'b0;
         ram_wdata <= 16'h0000;
         xreg_sel <= flag_cond_pkg::xr_ptr0;
         xreg_wr <= 1'b0;
         xreg_wdata <= 36'h0_0000_0000;
      end else if (ce) begin
         ram_rd <= cmd_take;
         ram_wr <= st == flag_cond_pkg::seq_load;
         xreg_wr <= st == flag_cond_pkg::seq_load && !tgt_int;
         if (cmd_take) begin
            ram_addr <= core[{2'h0, cmd.ptr_sel}];
            xreg_sel <= cmd.target;
         end
         if (st == flag_cond_pkg::seq_load) begin
            ram_addr <= cur_ptr;
            ram_wdata <= temp_word;
            xreg_wdata <= load_val;
         end
      end
   end

   // Condition tests that touch counters or the random generator
   wire logic test_c0 = cond_valid && (cond == flag_cond_pkg::cond_count0_nonneg ||
                                       cond == flag_cond_pkg::cond_count0_neg);
   wire logic test_c1 = cond_valid && (cond == flag_cond_pkg::cond_count1_nonneg ||
                                       cond == flag_cond_pkg::cond_count1_neg);
   wire logic test_rand = cond_valid && (cond == flag_cond_pkg::cond_rand_set ||
                                         cond == flag_cond_pkg::cond_rand_clear);
   wire logic c0_neg = core[`IDX_CNT0][15];
   wire logic c1_neg = core[`IDX_CNT1][15];

   // Core registers: bus writes, pointer post-modification, internal loads, counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int n = 0; n < 10; n++) begin
            core[n] <= `CORE_RST;
         end
      end else if (ce) begin
         if (bus_core_wr) begin
            core[wa_idx] <= hwdata[15:0];
         end
         if (st == flag_cond_pkg::seq_read) begin
            core[ptr_idx] <= rd_next;
         end
         if (st == flag_cond_pkg::seq_load) begin
            core[ptr_idx] <= wr_next;
            if (tgt_int) begin
               core[tgt_idx] <= load_val[15:0];
            end
         end
         if (test_c0) begin
            core[`IDX_CNT0] <= 16'(core[`IDX_CNT0] + 16'h0001);
         end
         if (test_c1) begin
            core[`IDX_CNT1] <= 16'(core[`IDX_CNT1] + 16'h0001);
         end
      end
   end

   // Flags follow function and special results only
   wire logic flag_take = dau_valid && (dau.src == flag_cond_pkg::src_function ||
                                        dau.src == flag_cond_pkg::src_special);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_negative <= 1'b0;
         flag_zero <= 1'b0;
         flag_ovf36 <= 1'b0;
         flag_ovf32 <= 1'b0;
      end else if (ce && flag_take) begin
         flag_negative <= dau.value[35];
         flag_zero <= dau.value == 36'h0_0000_0000;
         flag_ovf36 <= dau.ovf36;
         flag_ovf32 <= ovf32_of(dau.value);
      end
   end

   // Condition evaluation
   logic cond_now;
   always_comb begin
      case (cond)
         flag_cond_pkg::cond_nonneg: cond_now = !flag_negative;
         flag_cond_pkg::cond_neg: cond_now = flag_negative;
         flag_cond_pkg::cond_eq: cond_now = flag_zero;
         flag_cond_pkg::cond_ne: cond_now = !flag_zero;
         flag_cond_pkg::cond_gt: cond_now = !flag_negative && !flag_zero;
         flag_cond_pkg::cond_le: cond_now = flag_negative || flag_zero;
         flag_cond_pkg::cond_ovf36_set: cond_now = flag_ovf36;
         flag_cond_pkg::cond_ovf36_clear: cond_now = !flag_ovf36;
         flag_cond_pkg::cond_ovf32_set: cond_now = flag_ovf32;
         flag_cond_pkg::cond_ovf32_clear: cond_now = !flag_ovf32;
         flag_cond_pkg::cond_count0_nonneg: cond_now = !c0_neg;
         flag_cond_pkg::cond_count0_neg: cond_now = c0_neg;
         flag_cond_pkg::cond_count1_nonneg: cond_now = !c1_neg;
         flag_cond_pkg::cond_count1_neg: cond_now = c1_neg;
         flag_cond_pkg::cond_rand_set: cond_now = rand_bit;
         flag_cond_pkg::cond_rand_clear: cond_now = !rand_bit;
         flag_cond_pkg::cond_always: cond_now = 1'b1;
         flag_cond_pkg::cond_never: cond_now = 1'b0;
         default: cond_now = 1'b0;
      endcase
   end

   // Test answer, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_done <= 1'b0;
         cond_pass <= 1'b0;
      end else if (ce) begin
         cond_done <= cond_valid;
         if (cond_valid) begin
            cond_pass <= cond_now;
         end
      end
   end

   // Interrupt return register and random generator
   wire logic any_ret_wr = ret_wr || bus_ret_wr;
   wire logic [15:0] ret_in = ret_wr ? ret_wdata : hwdata[15:0];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_return_reg <= `RET_RST;
         rand_state <= `RAND_SEED;
      end else if (ce) begin
         if (any_ret_wr && in_isr) begin
            interrupt_return_reg <= ret_in;
         end
         if (any_ret_wr) begin
            rand_state <= `RAND_SEED;
         end else if (test_rand) begin
            rand_state <= rand_state == `RAND_LAST ? `RAND_SEED :
                          4'(rand_state + 4'h1);
         end
      end
   end

endmodule
`default_nettype wire

//--- ram_model.sv
`timescale 1ns/10ps
`default_nettype none
// Synchronous data RAM with a registered read port
module ram_model (
   input wire logic clk,
   input wire logic rd,
   input wire logic wr,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [15:0] mem [0:255];
   // Marker byte over the address
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = {8'h5A, 8'(i)};
      rdata = 16'hDEAD;
   end
   // Registered read port
   always @(posedge clk) begin
      if (rd)
         rdata <= mem[addr[7:0]];
      if (wr)
         mem[addr[7:0]] <= wdata;
   end
endmodule
`default_nettype wire

//--- compound_access_and_condition_flags_sva.sv
`timescale 1ns/10ps
`default_nettype none
module compound_access_and_condition_flags_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic busy,
   input wire logic ram_rd,
   input wire logic ram_wr,
   input wire logic dau_valid,
   input wire flag_cond_pkg::dau_result_t dau,
   input wire logic cond_valid,
   input wire flag_cond_pkg::cond_t cond,
   input wire logic cond_done,
   input wire logic cond_pass,
   input wire logic flag_negative,
   input wire logic flag_zero,
   input wire logic flag_ovf36,
   input wire logic flag_ovf32
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Flag update and current test code
   wire logic upd = dau_valid && !dau.src[1];
   wire logic [4:0] code = cond_valid ? 5'(cond) : 5'h1F;
   // Read, quiet cycle, write-back
   sequence s_read;
      busy && ram_rd && !ram_wr;
   endsequence
   sequence s_store;
      !ram_rd && !ram_wr ##1 ram_wr;
   endsequence
   a_access_steps: assert property (cmd_valid && !busy |=> s_read ##1 s_store)
      else $error("exchange steps out of order");
   a_read_first: assert property (ram_wr |-> $past(ram_rd, 2))
      else $error("write-back without read");
   a_done_pulse: assert property (cond_valid |=> cond_done)
      else $error("test not answered");
   a_always_pass: assert property (code == 5'h10 |=> cond_pass)
      else $error("always test failed");
   a_never_pass: assert property (code == 5'h11 |=> !cond_pass)
      else $error("never test passed");
   a_neg_test: assert property (code == 5'h01 |=> cond_pass == $past(flag_negative))
      else $error("negative test wrong");
   a_le_test: assert property (code == 5'h05 |=>
      cond_pass == ($past(flag_negative) || $past(flag_zero))) else $error("le test wrong");
   a_ovf_test: assert property (code == 5'h07 |=> cond_pass != $past(flag_ovf36))
      else $error("overflow clear test wrong");
   a_neg_flag: assert property (upd |=> flag_negative == $past(dau.value[35]))
      else $error("negative flag wrong");
   a_zero_flag: assert property (upd |=> flag_zero == ($past(dau.value) == 36'h0))
      else $error("zero flag wrong");
   a_ovf36_flag: assert property (upd |=> flag_ovf36 == $past(dau.ovf36))
      else $error("36-bit overflow flag wrong");
   a_ovf32_flag: assert property (upd |=>
      flag_ovf32 != ($past(dau.value[35:31]) inside {5'h00, 5'h1F}))
      else $error("32-bit overflow flag wrong");
   a_flags_kept: assert property (dau_valid && dau.src[1] |=>
      $stable(flag_negative) && $stable(flag_zero)) else $error("flags changed by a load");
endmodule
bind compound_access_and_condition_flags compound_access_and_condition_flags_sva sva (.*);
`default_nettype wire

//--- compound_access_and_condition_flags_test.sv
`timescale 1ns/10ps
`default_nettype none
module compound_access_and_condition_flags_test;
   logic clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, cmd_valid, busy, ram_rd, ram_wr;
   logic xreg_wr, dau_valid, cond_valid, cond_done, cond_pass, ret_wr, in_isr;
   logic flag_negative, flag_zero, flag_ovf36, flag_ovf32;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] f;
   logic [22:0] bits;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [15:0] ram_addr, ram_wdata, ram_rdata, ret_wdata, interrupt_return_reg, wr_addr, p;
   logic [35:0] xreg_old, xreg_wdata, ld_val, v;
   flag_cond_pkg::compound_cmd_t cmd;
   flag_cond_pkg::xreg_t xreg_sel;
   flag_cond_pkg::dau_result_t dau;
   flag_cond_pkg::cond_t cond;
   int errors = 0;
   int n_tests = 0;
   int wa[4] = '{0, 1, 0, 3};
   int fo[4] = '{1, 1, 2, 8};
   logic [35:0] vals[4] = '{36'h0, 36'h8_0000_0000, 36'h5, 36'hF_FFFF_FFFF};

   compound_access_and_condition_flags dut (
      .clk, .rst_n, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hrdata, .hresp, .cmd_valid, .cmd, .busy, .ram_addr, .ram_rd, .ram_wr,
      .ram_wdata, .ram_rdata, .xreg_old, .xreg_sel, .xreg_wr, .xreg_wdata, .dau_valid, .dau,
      .cond_valid, .cond, .cond_done, .cond_pass, .ret_wr, .ret_wdata, .in_isr,
      .interrupt_return_reg, .flag_negative, .flag_zero, .flag_ovf36, .flag_ovf32);
   ram_model ram (.clk, .rd(ram_rd), .wr(ram_wr), .addr(ram_addr), .wdata(ram_wdata),
      .rdata(ram_rdata));

   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Last write address and loaded value
   always @(posedge clk) begin
      if (ram_wr)
         wr_addr <= ram_addr;
      if (xreg_wr)
         ld_val <= xreg_wdata;
   end

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One single-word bus transfer; read data lands in q
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge clk iff hreadyout === 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk iff hreadyout === 1'b1);
      q = hrdata;
   endtask
   // Compound exchange; the sequence needs four cycles
   task automatic xchg(input logic [1:0] m, input logic [1:0] ps, input logic [4:0] t,
         input logic [35:0] old);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{flag_cond_pkg::xmode_t'(m), ps, flag_cond_pkg::xreg_t'(t)};
      xreg_old <= old;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   task automatic tst(input logic [4:0] c);
      @(posedge clk);
      cond_valid <= 1'b1;
      cond <= flag_cond_pkg::cond_t'(c);
      @(posedge clk);
      cond_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic res(input logic [1:0] s, input logic o, input logic [35:0] val);
      @(posedge clk);
      dau_valid <= 1'b1;
      dau <= '{flag_cond_pkg::flag_src_t'(s), o, val};
      @(posedge clk);
      dau_valid <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ret(input logic isr, input logic [15:0] d);
      @(posedge clk);
      ret_wr <= 1'b1;
      in_isr <= isr;
      ret_wdata <= d;
      @(posedge clk);
      ret_wr <= 1'b0;
      @(posedge clk);
   endtask
   // Expected flag test result; fl is {ovf32, ovf36, zero, neg}
   function automatic logic expc(input int k, input logic [3:0] fl);
      logic [17:0] t;
      t = {2'h1, 6'h00, !fl[3], fl[3], !fl[2], fl[2], fl[0] || fl[1],
           !fl[0] && !fl[1], !fl[1], fl[1], fl[0], !fl[0]};
      return t[k];
   endfunction
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Cut a hang short
   initial begin
      repeat (6000) @(posedge clk);
      errors++;
      test_done();
   end

   initial begin
      {rst_n, hsel, hwrite, cmd_valid, dau_valid, cond_valid, ret_wr, in_isr} = '0;
      {haddr, hwdata, htrans, xreg_old, ret_wdata} = '0;
      cmd = '0;
      dau = '0;
      cond = flag_cond_pkg::cond_never;
      ce = 1'b1;
      hsize = 3'h2;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Modulo bounds and the two step sizes
      bus(1'b1, 8'h58, 32'h80);
      bus(1'b1, 8'h5C, 32'h90);
      bus(1'b1, 8'h50, 32'h3);
      bus(1'b1, 8'h54, 32'h5);
      // One exchange per mode and pointer
      for (int m = 0; m < 4; m++) begin
         p = 16'(16 * (m + 1));
         bus(1'b1, 8'(64 + 4 * m), 32'(p));
         xchg(2'(m), 2'(m), 5'h0B, 36'(16'hC000 + m));
         chk("write address", 36'(p + 16'(wa[m])), 36'(wr_addr));
         chk("stored old value", 36'(16'hC000 + m), 36'(ram.mem[p[7:0] + 8'(wa[m])]));
         chk("loaded value", 36'(16'h5A00 + p), 36'(ld_val[15:0]));
         bus(1'b0, 8'(64 + 4 * m), 32'h0);
         chk("pointer after", 36'(p + 16'(fo[m])), 36'(q));
      end
      // Pointer at the modulo end, +1 modes
      for (int m = 0; m < 2; m++) begin
         bus(1'b1, 8'h40, 32'h90);
         xchg(2'(m), 2'h0, 5'h0B, 36'h1);
         chk("wrap write address", m ? 36'h80 : 36'h90, 36'(wr_addr));
         bus(1'b0, 8'h40, 32'h0);
         chk("wrap pointer", 36'h80, 36'(q));
      end
      // y load with low clear, then accumulator
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h44, 32'hA0);
      xchg(2'h0, 2'h1, 5'h0C, 36'h0_1234_5678);
      chk("y load", 36'h0_5AA0_0000, ld_val);
      chk("y stored", 36'h1234, 36'(ram.mem[8'hA0]));
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b1, 8'h44, 32'hB0);
      xchg(2'h0, 2'h1, 5'h18, 36'h0_8765_4321);
      chk("accumulator load", 36'h0_5AB0_4321, ld_val);
      chk("accumulator stored", 36'h8765, 36'(ram.mem[8'hB0]));
      // Each flag pattern against every flag test
      for (int i = 0; i < 4; i++) begin
         v = vals[i];
         f = {v[35:31] != 5'h00 && v[35:31] != 5'h1F, i[0], v == 36'h0, v[35]};
         res({1'b0, i[1]}, i[0], v);
         chk("flags", 36'(f), 36'({flag_ovf32, flag_ovf36, flag_zero, flag_negative}));
         for (int k = 0; k < 18; k++)
            if (k < 10 || k > 15) begin
               tst(5'(k));
               chk("test result", 36'(expc(k, f)), 36'(cond_pass));
            end
      end
      res(2'h2, 1'b0, 36'h0);
      res(2'h3, 1'b0, 36'h0);
      chk("flags kept", 36'(f), 36'({flag_ovf32, flag_ovf36, flag_zero, flag_negative}));
      // Counter tests at the sign boundaries
      bus(1'b1, 8'h60, 32'hFFFF);
      bus(1'b1, 8'h64, 32'h7FFF);
      tst(5'h0B);
      chk("counter0 below zero", 36'h1, 36'(cond_pass));
      tst(5'h0A);
      chk("counter0 at zero", 36'h1, 36'(cond_pass));
      tst(5'h0D);
      chk("counter1 positive", 36'h0, 36'(cond_pass));
      tst(5'h0C);
      chk("counter1 wrapped", 36'h0, 36'(cond_pass));
      bus(1'b0, 8'h60, 32'h0);
      chk("counter0", 36'h1, 36'(q));
      bus(1'b0, 8'h64, 32'h0);
      chk("counter1", 36'h8001, 36'(q));
      // Random bit, restarted by a return-register write
      ret(1'b0, 16'h1234);
      chk("return kept", 36'h0, 36'(interrupt_return_reg));
      for (int r = 0; r < 23; r++) begin
         if (r == 13)
            ret(1'b1, 16'hBEEF);
         tst(r[0] ? 5'h0F : 5'h0E);
         bits[r] = cond_pass ^ r[0];
      end
      chk("return stored", 36'hBEEF, 36'(interrupt_return_reg));
      chk("random ones", 36'h5, 36'($countones(bits[9:0])));
      chk("random restart", 36'(bits[9:0]), 36'(bits[22:13]));
      bus(1'b0, 8'hFC, 32'h0);
      chk("unmapped read", 36'h0, 36'(q));
      test_done();
   end
endmodule
`default_nettype wire
